// ===== frame_mux_params.svh
/*
  Constants of the E2/E3/G.747 frame multiplexer: set lengths, alignment
  patterns, overhead positions and FIFO shape.
  Assumes it is included by the design file after the type package.
*/
`ifndef FRAME_MUX_PARAMS_SVH
`define FRAME_MUX_PARAMS_SVH

// ----------------------------------------
// Frame shape
// ----------------------------------------
`define E2_SET_BITS  9'd212
`define E3_SET_BITS  9'd384
`define G7_SET_BITS  9'd168
`define E_SET_LAST   3'd3
`define G7_SET_LAST  3'd4
`define E_FAS        10'h3d0
`define G7_FAS       10'h1d0
`define E_FAS_LEN    9'd10
`define G7_FAS_LEN   9'd9
`define E_TRIB_LAST  2'd3
`define G7_TRIB_LAST 2'd2
`define E_CTRL_SET   3'd1
`define G7_CTRL_SET  3'd2
`define G7_OVH_SET   3'd1
`define G7_RAI_POS   9'd0
`define G7_PAR_POS   9'd1
`define G7_RSV_POS   9'd2
`define RSV_VALUE    1'b1
`define STUFF_FILL   1'b0

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
`define FIFO_WIDTH   3
`define FIFO_DEPTH   16

`endif

// ===== frame_mux_pkg.sv
/*
  Types of the E2/E3/G.747 frame multiplexer.
  Assumes nothing of its surroundings.
*/
package frame_mux_pkg;
    typedef enum logic [1:0] {
        MODE_E2   = 2'h0,
        MODE_E3   = 2'h1,
        MODE_G747 = 2'h2
    } mode_t;

    typedef enum logic [2:0] {
        SLOT_DATA   = 3'h0,
        SLOT_FAS    = 3'h1,
        SLOT_RAI    = 3'h2,
        SLOT_NAT    = 3'h3,
        SLOT_PARITY = 3'h4,
        SLOT_RSV    = 3'h5,
        SLOT_CTRL   = 3'h6,
        SLOT_STUFF  = 3'h7
    } slot_t;

    typedef enum logic [1:0] {
        RX_HUNT = 2'h0,
        RX_SYNC = 2'h1
    } rx_state_t;
endpackage

// ===== frame_mux.sv
/*
  Holds the E2/E3/G.747 frame multiplexer, its demultiplexer and the
  receive tributary FIFO.
  Assumes one clock, bit pace set by the tx_ready_in and rx_valid_in
  handshakes, tributary bits always present, and a static mode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frame_mux_params.svh"

// ----------------------------------------
// Receive tributary FIFO
// ----------------------------------------
module sync_fifo
#(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;
    logic             full;
    logic             empty;

    assign empty = (wr_r == rd_r);
    assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem[rd_r[AW-1:0]];

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            wr_r <= '0;
        else if (in_valid_in && !full)
            wr_r <= wr_r + {{AW{1'b0}}, 1'b1};
    end

    always_ff @(posedge clk_in)
    begin
        if (in_valid_in && !full)
            mem[wr_r[AW-1:0]] <= in_data_in;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rd_r <= '0;
        else if (out_ready_in && !empty)
            rd_r <= rd_r + {{AW{1'b0}}, 1'b1};
    end
endmodule

// ----------------------------------------
// Frame multiplexer and demultiplexer
// ----------------------------------------
module frame_mux
    import frame_mux_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    // Configuration
    input  wire logic [1:0] mode_in,
    // Transmit tributaries
    input  wire logic [3:0] trib_bit_in,
    output logic      [3:0] trib_take_out,
    input  wire logic [3:0] stuff_req_in,
    input  wire logic       rai_in,
    input  wire logic       national_bit_in,
    // Transmit aggregate
    output logic            tx_bit_out,
    output logic            tx_valid_out,
    input  wire logic       tx_ready_in,
    output logic            tx_sof_out,
    // Receive aggregate
    input  wire logic       rx_bit_in,
    input  wire logic       rx_valid_in,
    output logic            rx_ready_out,
    // Receive status
    output logic            rx_sync_out,
    output logic            rx_rai_out,
    output logic            national_bit_out,
    output logic            parity_err_out,
    // Receive tributaries
    output logic            rxd_valid_out,
    input  wire logic       rxd_ready_in,
    output logic      [1:0] rxd_trib_out,
    output logic            rxd_bit_out
);
    // ----------------------------------------
    // Frame geometry
    // ----------------------------------------
    function automatic logic [8:0] bit_last(input mode_t m);
        if (m == MODE_G747)
            bit_last = `G7_SET_BITS - 9'd1;
        else if (m == MODE_E3)
            bit_last = `E3_SET_BITS - 9'd1;
        else
            bit_last = `E2_SET_BITS - 9'd1;
    endfunction

    function automatic logic [2:0] set_last(input mode_t m);
        set_last = (m == MODE_G747) ? `G7_SET_LAST : `E_SET_LAST;
    endfunction

    function automatic logic [1:0] trib_last(input mode_t m);
        trib_last = (m == MODE_G747) ? `G7_TRIB_LAST : `E_TRIB_LAST;
    endfunction

    function automatic logic [8:0] fas_len(input mode_t m);
        fas_len = (m == MODE_G747) ? `G7_FAS_LEN : `E_FAS_LEN;
    endfunction

    function automatic logic [2:0] ctrl_set(input mode_t m);
        ctrl_set = (m == MODE_G747) ? `G7_CTRL_SET : `E_CTRL_SET;
    endfunction

    // Tributary of a position; sets are whole rotations
    function automatic logic [1:0] trib_of(input mode_t m, input logic [8:0] b);
        trib_of = (m == MODE_G747) ? 2'(b % 9'd3) : b[1:0];
    endfunction

    function automatic logic maj3(input logic [2:0] c);
        maj3 = (c[0] & c[1]) | (c[0] & c[2]) | (c[1] & c[2]);
    endfunction

    function automatic logic fas_bit(input mode_t m, input logic [8:0] b);
        logic [9:0] p;
        logic [8:0] i;
        p = (m == MODE_G747) ? `G7_FAS : `E_FAS;
        i = fas_len(m) - 9'd1 - b;
        fas_bit = p[i[3:0]];
    endfunction

    // Next position, set in [11:9], bit in [8:0]
    function automatic logic [11:0] next_pos(input mode_t m, input logic [2:0] s,
                                             input logic [8:0] b);
        if (b != bit_last(m))
            next_pos = {s, b + 9'd1};
        else if (s != set_last(m))
            next_pos = {s + 3'd1, 9'h0};
        else
            next_pos = 12'h0;
    endfunction

    function automatic slot_t slot_of(input mode_t m, input logic [2:0] s,
                                      input logic [8:0] b);
        logic [8:0] fl;
        logic [8:0] nt;
        logic       g;
        g = (m == MODE_G747);
        fl = fas_len(m);
        nt = {7'h0, trib_last(m)} + 9'd1;
        slot_of = SLOT_DATA;
        if (s == 3'h0)
        begin
            if (b < fl)
                slot_of = SLOT_FAS;
            else if (!g && b == fl)
                slot_of = SLOT_RAI;
            else if (!g && b == fl + 9'd1)
                slot_of = SLOT_NAT;
        end
        else if (g && s == `G7_OVH_SET)
        begin
            if (b == `G7_RAI_POS)
                slot_of = SLOT_RAI;
            else if (b == `G7_PAR_POS)
                slot_of = SLOT_PARITY;
            else if (b == `G7_RSV_POS)
                slot_of = SLOT_RSV;
        end
        else if (s >= ctrl_set(m))
        begin
            if (b < nt)
                slot_of = SLOT_CTRL;
            else if (s == set_last(m) && b < nt + nt)
                slot_of = SLOT_STUFF;
        end
    endfunction

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    mode_t      mode_r;
    logic       tx_valid_r;
    logic       tx_bit_r;
    logic       tx_sof_r;
    logic [2:0] tx_s_r;
    logic [8:0] tx_b_r;
    logic [3:0] just_r;
    logic       tx_acc_r;
    logic       tributary_parity_bit_r;
    logic       tx_load;
    logic [2:0] tx_ns;
    logic [8:0] tx_nb;
    slot_t      tx_slot;
    logic [1:0] tx_trib;
    logic       tx_data;
    logic       tx_nbit;
    logic       tx_start;

    rx_state_t  rx_state_r;
    logic [2:0] rx_s_r;
    logic [8:0] rx_b_r;
    logic [8:0] sh_r;
    logic [2:0] c_r [0:3];
    logic       rx_rai_r;
    logic       rx_nat_r;
    logic       rx_perr_r;
    logic       rx_acc_r;
    logic       rx_par_r;
    logic       rx_pv_r;
    logic       rx_acc;
    logic [9:0] sh_nxt;
    logic       fas_hit;
    slot_t      rx_slot;
    logic [1:0] rx_trib;
    logic [1:0] rx_ctl;
    logic       rx_sync;
    logic       rx_fas_end;
    logic       rx_push;
    logic       fifo_ready;
    logic [2:0] fifo_out;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            mode_r <= MODE_E2;
        else
            mode_r <= mode_t'(mode_in);
    end

    // ----------------------------------------
    // Transmit framer
    // ----------------------------------------
    always_comb
    begin
        tx_load = !tx_valid_r || tx_ready_in;
        {tx_ns, tx_nb} = tx_valid_r ? next_pos(mode_r, tx_s_r, tx_b_r) : 12'h0;
        tx_start = (tx_ns == 3'h0) && (tx_nb == 9'h0);
        tx_slot = slot_of(mode_r, tx_ns, tx_nb);
        tx_trib = trib_of(mode_r, tx_nb);
        tx_data = (tx_slot == SLOT_DATA) || (tx_slot == SLOT_STUFF && !just_r[tx_trib]);
        case (tx_slot)
            SLOT_FAS:    tx_nbit = fas_bit(mode_r, tx_nb);
            SLOT_RAI:    tx_nbit = rai_in;
            SLOT_NAT:    tx_nbit = national_bit_in;
            SLOT_PARITY: tx_nbit = tributary_parity_bit_r;
            SLOT_RSV:    tx_nbit = `RSV_VALUE;
            SLOT_CTRL:   tx_nbit = just_r[tx_trib];
            SLOT_STUFF:  tx_nbit = just_r[tx_trib] ? `STUFF_FILL : trib_bit_in[tx_trib];
            default:     tx_nbit = trib_bit_in[tx_trib];
        endcase
    end

    assign trib_take_out = (tx_load && tx_data) ? (4'h1 << tx_trib) : 4'h0;
    assign tx_bit_out = tx_bit_r;
    assign tx_valid_out = tx_valid_r;
    assign tx_sof_out = tx_sof_r;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tx_valid_r <= 1'b0;
            tx_bit_r <= 1'b0;
            tx_sof_r <= 1'b0;
            tx_s_r <= 3'h0;
            tx_b_r <= 9'h0;
        end
        else if (tx_load)
        begin
            tx_valid_r <= 1'b1;
            tx_bit_r <= tx_nbit;
            tx_sof_r <= tx_start;
            tx_s_r <= tx_ns;
            tx_b_r <= tx_nb;
        end
    end

    // Justification requests and parity, latched per frame
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            just_r <= 4'h0;
            tx_acc_r <= 1'b0;
            tributary_parity_bit_r <= 1'b0;
        end
        else if (tx_load && tx_start)
        begin
            just_r <= stuff_req_in;
            tributary_parity_bit_r <= tx_acc_r;
            tx_acc_r <= 1'b0;
        end
        else if (tx_load && (tx_slot == SLOT_DATA || tx_slot == SLOT_STUFF))
            tx_acc_r <= tx_acc_r ^ tx_nbit;
    end

    // ----------------------------------------
    // Receive framer
    // ----------------------------------------
    always_comb
    begin
        rx_acc = rx_valid_in && fifo_ready;
        sh_nxt = {sh_r, rx_bit_in};
        fas_hit = (mode_r == MODE_G747) ? ({1'b0, sh_nxt[8:0]} == `G7_FAS) : (sh_nxt == `E_FAS);
        rx_slot = slot_of(mode_r, rx_s_r, rx_b_r);
        rx_trib = trib_of(mode_r, rx_b_r);
        rx_ctl = 2'(rx_s_r - ctrl_set(mode_r));
        rx_sync = (rx_state_r == RX_SYNC);
        rx_fas_end = (rx_s_r == 3'h0) && (rx_b_r == fas_len(mode_r) - 9'd1);
        rx_push = rx_acc && rx_sync && ((rx_slot == SLOT_DATA) ||
                  (rx_slot == SLOT_STUFF && !maj3(c_r[rx_trib])));
    end

    assign rx_ready_out = fifo_ready;
    assign rx_sync_out = rx_sync;
    assign rx_rai_out = rx_rai_r;
    assign national_bit_out = rx_nat_r;
    assign parity_err_out = rx_perr_r;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_state_r <= RX_HUNT;
            rx_s_r <= 3'h0;
            rx_b_r <= 9'h0;
            sh_r <= 9'h0;
        end
        else if (rx_acc)
        begin
            sh_r <= sh_nxt[8:0];
            case (rx_state_r)
                RX_HUNT:
                    if (fas_hit)
                    begin
                        rx_state_r <= RX_SYNC;
                        rx_s_r <= 3'h0;
                        rx_b_r <= fas_len(mode_r);
                    end
                default:
                    if (rx_fas_end && !fas_hit)
                        rx_state_r <= RX_HUNT;
                    else
                        {rx_s_r, rx_b_r} <= next_pos(mode_r, rx_s_r, rx_b_r);
            endcase
        end
    end

    // Overhead capture
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_rai_r <= 1'b0;
            rx_nat_r <= 1'b0;
            for (int i = 0; i < 4; i++)
                c_r[i] <= 3'h0;
        end
        else if (rx_acc && rx_sync)
        begin
            if (rx_slot == SLOT_RAI)
                rx_rai_r <= rx_bit_in;
            if (rx_slot == SLOT_NAT)
                rx_nat_r <= rx_bit_in;
            if (rx_slot == SLOT_CTRL)
                c_r[rx_trib][rx_ctl] <= rx_bit_in;
        end
    end

    // Parity check against the previous frame
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_acc_r <= 1'b0;
            rx_par_r <= 1'b0;
            rx_pv_r <= 1'b0;
            rx_perr_r <= 1'b0;
        end
        else
        begin
            rx_perr_r <= rx_acc && rx_sync && rx_pv_r && rx_slot == SLOT_PARITY &&
                         rx_bit_in != rx_par_r;
            if (!rx_sync)
            begin
                rx_acc_r <= 1'b0;
                rx_pv_r <= 1'b0;
            end
            else if (rx_acc && rx_s_r == 3'h0 && rx_b_r == 9'h0)
            begin
                rx_par_r <= rx_acc_r;
                rx_pv_r <= 1'b1;
                rx_acc_r <= 1'b0;
            end
            else if (rx_acc && (rx_slot == SLOT_DATA || rx_slot == SLOT_STUFF))
                rx_acc_r <= rx_acc_r ^ rx_bit_in;
        end
    end

    sync_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (rx_push),
        .in_ready_out  (fifo_ready),
        .in_data_in    ({rx_trib, rx_bit_in}),
        .out_valid_out (rxd_valid_out),
        .out_ready_in  (rxd_ready_in),
        .out_data_out  (fifo_out)
    );

    assign rxd_trib_out = fifo_out[2:1];
    assign rxd_bit_out = fifo_out[0];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_tx_fas_bits: assert property (
        tx_valid_r && slot_of(mode_r, tx_s_r, tx_b_r) == SLOT_FAS
        |-> tx_bit_out == fas_bit(mode_r, tx_b_r))
        else $error("alignment bit wrong");
    a_tx_rsv_one: assert property (
        tx_valid_r && slot_of(mode_r, tx_s_r, tx_b_r) == SLOT_RSV |-> tx_bit_out)
        else $error("reserved bit not one");
    a_tx_parity_bit: assert property (
        tx_valid_r && slot_of(mode_r, tx_s_r, tx_b_r) == SLOT_PARITY
        |-> tx_bit_out == tributary_parity_bit_r)
        else $error("parity bit wrong");
    a_tx_ctrl_bit: assert property (
        tx_valid_r && slot_of(mode_r, tx_s_r, tx_b_r) == SLOT_CTRL
        |-> tx_bit_out == just_r[trib_of(mode_r, tx_b_r)])
        else $error("control bit wrong");
    a_tx_stuff_fill: assert property (
        tx_valid_r && slot_of(mode_r, tx_s_r, tx_b_r) == SLOT_STUFF &&
        just_r[trib_of(mode_r, tx_b_r)] |-> tx_bit_out == `STUFF_FILL)
        else $error("filler wrong");
    a_tx_take_one: assert property (
        trib_take_out != 4'h0 |-> tx_load && $onehot(trib_take_out))
        else $error("bad tributary take");
    a_tx_bit_order: assert property (
        tx_valid_r && tx_ready_in && tx_b_r != bit_last(mode_r)
        |=> tx_b_r == $past(tx_b_r) + 9'd1 && tx_s_r == $past(tx_s_r))
        else $error("bit order broken");
    a_tx_frame_wrap: assert property (
        tx_valid_r && tx_ready_in && tx_b_r == bit_last(mode_r) &&
        tx_s_r == set_last(mode_r) |=> tx_sof_out && tx_s_r == 3'h0)
        else $error("frame wrap wrong");
    a_rx_sync_lost: assert property (
        rx_sync && rx_acc && rx_fas_end && !fas_hit |=> !rx_sync_out ##1 !rx_push)
        else $error("sync not dropped");
endmodule
`default_nettype wire

// ===== frame_partner.sv
/*
  Far-side model: the next multiplex stage, echoing the aggregate back.
  Assumes one clock shared with the multiplexer.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_partner
(
    // Clock, pacing and bit inversion
    input  wire logic clk_in,
    input  wire logic slow_in,
    input  wire logic hold_in,
    input  wire logic flip_in,
    // Aggregate from the multiplexer
    input  wire logic tx_bit_in,
    input  wire logic tx_valid_in,
    output logic      tx_ready_out,
    // Aggregate back into the demultiplexer
    output logic      rx_bit_out,
    output logic      rx_valid_out,
    input  wire logic rx_ready_in
);
    logic pace_r;

    always_ff @(posedge clk_in)
    begin
        pace_r <= slow_in ? ~pace_r : 1'b1;
    end

    // Takes a bit only when it can pass it on
    assign tx_ready_out = pace_r & rx_ready_in & ~hold_in;
    assign rx_valid_out = tx_valid_in & tx_ready_out;
    // Idle line shows the inverse, never a stale copy
    assign rx_bit_out   = rx_valid_out ? (tx_bit_in ^ flip_in) : ~tx_bit_in;
endmodule
`default_nettype wire

// ===== tb.sv
/*
  Self-checking bench of the frame multiplexer, looped back by the partner.
  Assumes the design, its package and its constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frame_mux_params.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((ex) !== (got)) begin error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb
    import frame_mux_pkg::*;
;
    logic       clk_in = 1'b0;
    logic       rst_b_in = 1'b0;
    logic [1:0] mode_in = MODE_E2;
    logic [3:0] trib_bit_in = 4'hd;
    logic [3:0] stuff_req_in = 4'h5;
    logic       rai_in = 1'b0;
    logic       national_bit_in = 1'b0;
    logic       rxd_ready_in = 1'b1;
    logic       slow = 1'b0;
    logic       hold = 1'b0;
    logic       flip = 1'b0;
    wire  [3:0] trib_take_out;
    wire        tx_bit_out, tx_valid_out, tx_ready_in, tx_sof_out;
    wire        rx_bit_in, rx_valid_in, rx_ready_out, rx_sync_out, rx_rai_out;
    wire        national_bit_out, parity_err_out, rxd_valid_out, rxd_bit_out;
    wire  [1:0] rxd_trib_out;
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         pop_cnt = 0;
    logic [5:0] cap_q[$];

    always #10 clk_in = ~clk_in;

    frame_mux frame_mux_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .mode_in(mode_in),
        .trib_bit_in(trib_bit_in), .trib_take_out(trib_take_out), .stuff_req_in(stuff_req_in),
        .rai_in(rai_in), .national_bit_in(national_bit_in), .tx_bit_out(tx_bit_out),
        .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .tx_sof_out(tx_sof_out),
        .rx_bit_in(rx_bit_in), .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out),
        .rx_sync_out(rx_sync_out), .rx_rai_out(rx_rai_out), .national_bit_out(national_bit_out),
        .parity_err_out(parity_err_out), .rxd_valid_out(rxd_valid_out),
        .rxd_ready_in(rxd_ready_in), .rxd_trib_out(rxd_trib_out), .rxd_bit_out(rxd_bit_out));

    frame_partner frame_partner_inst (.clk_in(clk_in), .slow_in(slow), .hold_in(hold),
        .flip_in(flip),
        .tx_bit_in(tx_bit_out), .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in),
        .rx_bit_out(rx_bit_in), .rx_valid_out(rx_valid_in), .rx_ready_in(rx_ready_out));

    task automatic conclude();
        begin
            $display("Counts: %0d compared, %0d mismatched", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // ----------------------------------------
    // Monitors and watchdog
    // ----------------------------------------
    always @(posedge clk_in)
    begin
        cyc++;
        if (rst_b_in && tx_valid_out === 1'b1 && tx_ready_in === 1'b1)
            cap_q.push_back({trib_take_out, tx_sof_out, tx_bit_out});
        if (rst_b_in && rxd_valid_out === 1'b1 && rxd_ready_in)
        begin
            pop_cnt++;
            `CHK("rx trib bit", trib_bit_in[rxd_trib_out], rxd_bit_out)
        end
        if (rst_b_in && parity_err_out !== 1'b0)
            `CHK("parity err", 1'b0, parity_err_out)
        if (cyc == 40000)
        begin
            error_cnt++;
            conclude();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic do_reset();
        begin
            rst_b_in = 1'b0;
            repeat (20) @(negedge clk_in);
            `CHK("tx valid in reset", 1'b0, tx_valid_out)
            `CHK("sync in reset", 1'b0, rx_sync_out)
            cap_q.delete();
            rst_b_in = 1'b1;
        end
    endtask

    task automatic run_mode(input logic [1:0] m, input int sb, input int ns, input int fl,
                            input int nt, input logic [9:0] fas, input logic sl);
        int   n, i, s, p, par;
        logic e, d;
        begin
            mode_in = m;
            rai_in = ~m[0];
            national_bit_in = m[0];
            stuff_req_in = (m == MODE_E2) ? 4'h5 : 4'ha;
            slow = sl;
            do_reset();
            n = sb * ns;
            par = 0;
            for (i = 0; i < 8 * n && cap_q.size() < 2 * n; i++)
                @(negedge clk_in);
            `CHK("frames", 1'b1, cap_q.size() >= 2 * n)
            for (i = 0; i < 2 * n && i < cap_q.size(); i++)
            begin
                s = (i % n) / sb;
                p = i % sb;
                e = trib_bit_in[i % nt];
                d = 1'b0;
                if (s == 0 && p < fl)
                    e = fas[fl - 1 - p];
                else if (nt == 4 && s == 0 && p == 10)
                    e = rai_in;
                else if (nt == 4 && s == 0 && p == 11)
                    e = national_bit_in;
                else if (nt == 3 && s == 1 && p < 3)
                    e = (p == 0) ? rai_in : (p == 1) ? (i >= n && par[0]) : 1'b1;
                else if (s >= ns - 3 && p < nt)
                    e = stuff_req_in[p];
                else if (s == ns - 1 && p >= nt && p < 2 * nt && stuff_req_in[p - nt])
                    e = 1'b0;
                else
                begin
                    d = 1'b1;
                    if (i < n)
                        par += int'(e);
                end
                `CHK("tx bit", e, cap_q[i][0])
                `CHK("sof", i % n == 0, cap_q[i][1])
                if (i > 0)
                    `CHK("take", d ? 4'h1 << (i % nt) : 4'h0, cap_q[i - 1][5:2])
            end
            `CHK("rx sync", 1'b1, rx_sync_out)
            `CHK("rx rai", rai_in, rx_rai_out)
            if (nt == 4)
                `CHK("rx national", national_bit_in, national_bit_out)
            $display("Test of mode %0d finished", m);
        end
    endtask

    task automatic lose_sync();
        int i;
        begin
            mode_in = MODE_E2;
            slow = 1'b0;
            do_reset();
            for (i = 0; i < 2000 && rx_sync_out !== 1'b1; i++)
                @(negedge clk_in);
            `CHK("sync found", 1'b1, rx_sync_out)
            for (i = 0; i < 2000 && tx_sof_out !== 1'b1; i++)
                @(negedge clk_in);
            flip = 1'b1;
            @(negedge clk_in);
            flip = 1'b0;
            for (i = 0; i < 20 && rx_sync_out !== 1'b0; i++)
                @(negedge clk_in);
            `CHK("sync lost", 1'b0, rx_sync_out)
            for (i = 0; i < 2000 && rx_sync_out !== 1'b1; i++)
                @(negedge clk_in);
            `CHK("sync regained", 1'b1, rx_sync_out)
            $display("Test of alignment loss finished");
        end
    endtask

    task automatic fill_drain();
        int i, c;
        begin
            mode_in = MODE_E2;
            slow = 1'b0;
            rxd_ready_in = 1'b0;
            do_reset();
            for (i = 0; i < 2000 && rx_ready_out !== 1'b0; i++)
                @(negedge clk_in);
            `CHK("fifo full", 1'b0, rx_ready_out)
            c = cap_q.size();
            repeat (5) @(negedge clk_in);
            `CHK("tx stalled", c, cap_q.size())
            hold = 1'b1;
            pop_cnt = 0;
            rxd_ready_in = 1'b1;
            for (i = 0; i < 40 && rxd_valid_out !== 1'b0; i++)
                @(negedge clk_in);
            `CHK("pops", 16, pop_cnt)
            `CHK("fifo empty", 1'b0, rxd_valid_out)
            hold = 1'b0;
            $display("Test of fill and drain finished");
        end
    endtask

    initial
    begin
        run_mode(MODE_E2, 212, 4, 10, 4, 10'h3d0, 1'b0);
        run_mode(MODE_E3, 384, 4, 10, 4, 10'h3d0, 1'b1);
        run_mode(MODE_G747, 168, 5, 9, 3, `G7_FAS, 1'b0);
        lose_sync();
        fill_drain();
        conclude();
    end
endmodule
`default_nettype wire
